// ===== design/dhp_pkg.sv
// package: timing and format constants for the hot attach monitor block
package dhp_pkg;
    // system clock rate
    localparam int unsigned CLK_HZ = 250_000_000;
    // removal-to-transmitter-off limit, in milliseconds
    localparam int unsigned TX_OFF_LIMIT_MS = 1000;
    // transmitter shutdown target, in milliseconds below the limit
    localparam int unsigned TX_OFF_TARGET_MS = 500;
    // cycles from removal to transmitter disable (rounded down)
    localparam int unsigned TX_OFF_CYCLES = (CLK_HZ / 1000) * TX_OFF_TARGET_MS;
    // monitor identification answer window after supply, in milliseconds
    localparam int unsigned ID_READY_MS = 250;
    localparam int unsigned ID_READY_CYCLES = (CLK_HZ / 1000) * ID_READY_MS;
    localparam int unsigned CNT_W = 32;
    // default low format, as width and height
    localparam logic [11:0] LOW_FMT_H = 12'h280;
    localparam logic [11:0] LOW_FMT_V = 12'h1E0;
    localparam logic [1:0] SYNC_RESET = 2'h0;
    localparam logic [CNT_W-1:0] CNT_RESET = 32'h0;

    typedef enum logic [1:0] {
        DHP_DETACHED,
        DHP_ATTACHED,
        DHP_DRAINING
    } dhp_state_t;
endpackage : dhp_pkg

// ===== design/dhp_sync_if.sv
// interface: synchronised hot attach level and edges
`timescale 1ns/1ns
interface dhp_sync_if;
    logic level;
    logic rise;
    logic fall;
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface : dhp_sync_if

// ===== design/dhp_edge_sync.sv
// two-stage synchroniser with edge detector for the hot attach line
`timescale 1ns/1ns
module dhp_edge_sync
    import dhp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic pinIn,
    dhp_sync_if.src sync
);
    typedef struct packed {
        logic meta;
        logic stable;
        logic prev;
    } dhp_sync_st_t;

    dhp_sync_st_t s_q;
    dhp_sync_st_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.meta = pinIn;
        s_d.stable = s_q.meta;
        s_d.prev = s_q.stable;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // edges look only at the second stage and its delayed copy
    assign sync.level = s_q.stable;
    assign sync.rise = s_q.stable & ~s_q.prev;
    assign sync.fall = ~s_q.stable & s_q.prev;
endmodule : dhp_edge_sync

// ===== design/dhp_hotplug.sv
// top: hot attach watcher, event pulses and transmitter shutdown timer
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/1ns
module dhp_hotplug
    import dhp_pkg::*;
#(
    parameter logic [CNT_W-1:0] TX_OFF_COUNT = CNT_W'(TX_OFF_CYCLES),
    parameter logic [CNT_W-1:0] ID_READY_COUNT = CNT_W'(ID_READY_CYCLES)
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic hotAttachSense,
    input wire logic idDataValid,
    input wire logic linkEnableReq,
    input wire logic hostScaleReq,
    input wire logic [11:0] nativeH,
    input wire logic [11:0] nativeV,
    output logic attachEvent,
    output logic removeEvent,
    output logic senseEvent,
    output logic monitorPresent,
    output logic idReadAllowed,
    output logic txEnable,
    output logic lowFormatOnly,
    output logic [11:0] scaleTargetH,
    output logic [11:0] scaleTargetV
);
    // ---------------------------------------------------------------
    // synchroniser
    // ---------------------------------------------------------------
    dhp_sync_if syncBus ();

    dhp_edge_sync uSync (
        .core_clk(core_clk),
        .rst(rst),
        .pinIn(hotAttachSense),
        .sync(syncBus)
    );

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        dhp_state_t state;
        logic [CNT_W-1:0] offCnt;
        logic [CNT_W-1:0] readyCnt;
        logic attachEv;
        logic removeEv;
        logic senseEv;
        logic present;
        logic idOk;
        logic tx;
        logic lowOnly;
        logic [11:0] tgtH;
        logic [11:0] tgtV;
    } dhp_top_st_t;

    // values held during and just after reset
    localparam dhp_top_st_t TOP_RESET = '{
        state: DHP_DETACHED,
        offCnt: CNT_RESET,
        readyCnt: CNT_RESET,
        attachEv: 1'b0,
        removeEv: 1'b0,
        senseEv: 1'b0,
        present: 1'b0,
        idOk: 1'b0,
        tx: 1'b0,
        lowOnly: 1'b1,
        tgtH: LOW_FMT_H,
        tgtV: LOW_FMT_V
    };

    dhp_top_st_t r_q;
    dhp_top_st_t r_d;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        r_d = r_q;
        // event pulses and level, one stage behind the synchroniser
        r_d.attachEv = syncBus.rise;
        r_d.removeEv = syncBus.fall;
        r_d.senseEv = syncBus.rise | syncBus.fall;
        r_d.present = syncBus.level;
        // attach, bring-up, removal and drain
        case (r_q.state)
            DHP_DETACHED: begin
                r_d.tx = 1'b0;
                r_d.idOk = 1'b0;
                r_d.readyCnt = CNT_RESET;
                if (syncBus.rise) begin
                    r_d.state = DHP_ATTACHED;
                end
            end
            DHP_ATTACHED: begin
                // wait out the monitor's identification bring-up
                if (r_q.readyCnt < ID_READY_COUNT) begin
                    r_d.readyCnt = r_q.readyCnt + 1'b1;
                end else begin
                    r_d.idOk = 1'b1;
                end
                // link only when software asks and the identification bring-up wait has ended
                r_d.tx = linkEnableReq & r_q.idOk;
                if (syncBus.fall) begin
                    r_d.state = DHP_DRAINING;
                    r_d.offCnt = CNT_RESET;
                    r_d.idOk = 1'b0;
                end
            end
            DHP_DRAINING: begin
                r_d.offCnt = r_q.offCnt + 1'b1;
                if (syncBus.rise) begin
                    // monitor back before the drain ended: link off, bring-up restarts
                    r_d.tx = 1'b0;
                    r_d.state = DHP_ATTACHED;
                    r_d.readyCnt = CNT_RESET;
                end else if (r_q.offCnt + 1'b1 >= TX_OFF_COUNT || !linkEnableReq) begin
                    r_d.tx = 1'b0;
                    r_d.state = DHP_DETACHED;
                    r_d.readyCnt = CNT_RESET;
                end
            end
            default: begin
                r_d.state = DHP_DETACHED;
                r_d.tx = 1'b0;
            end
        endcase
        // no valid identification means only the low format is assumed
        r_d.lowOnly = ~(r_d.idOk & idDataValid);
        if (r_d.lowOnly) begin
            r_d.tgtH = LOW_FMT_H;
            r_d.tgtV = LOW_FMT_V;
        end else if (hostScaleReq) begin
            r_d.tgtH = nativeH;
            r_d.tgtV = nativeV;
        end else begin
            r_d.tgtH = nativeH;
            r_d.tgtV = nativeV;
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            r_q <= TOP_RESET;
        end else begin
            r_q <= r_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs, straight from the state register
    // ---------------------------------------------------------------
    assign attachEvent = r_q.attachEv;
    assign removeEvent = r_q.removeEv;
    assign senseEvent = r_q.senseEv;
    assign monitorPresent = r_q.present;
    assign idReadAllowed = r_q.idOk;
    assign txEnable = r_q.tx;
    assign lowFormatOnly = r_q.lowOnly;
    assign scaleTargetH = r_q.tgtH;
    assign scaleTargetV = r_q.tgtV;
endmodule : dhp_hotplug

// ===== tb/dhp_mon_model.sv
// monitor model: sense line follows identification readiness
`timescale 1ns/1ns
module dhp_mon_model #(parameter int READY = 5) (
    input wire logic core_clk,
    input wire logic plugIn,
    output logic hotAttachSense = 1'b0,
    output logic idDataValid = 1'b0,
    output logic [11:0] nativeH,
    output logic [11:0] nativeV
);
    int cnt = 0;
    assign nativeH = 12'h780;
    assign nativeV = 12'h438;
    // table answers whenever plugged in, after the power-up delay
    always @(posedge core_clk) begin
        cnt <= plugIn ? cnt + 1 : 0;
        hotAttachSense <= plugIn && cnt >= READY;
        idDataValid <= plugIn && cnt >= READY;
    end
endmodule : dhp_mon_model

// ===== tb/dhp_hotplug_sva.sv
// port checker for the hot attach watcher
`timescale 1ns/1ns
module dhp_hotplug_sva
    import dhp_pkg::*;
#(parameter logic [CNT_W-1:0] TX_OFF_COUNT = 32'h10, parameter logic [CNT_W-1:0] ID_READY_COUNT = 32'h8)
(
    input wire logic core_clk, rst, hotAttachSense, idDataValid, linkEnableReq, hostScaleReq,
    input wire logic [11:0] nativeH, nativeV, scaleTargetH, scaleTargetV,
    input wire logic attachEvent, removeEvent, senseEvent, monitorPresent, idReadAllowed, txEnable, lowFormatOnly
);
    localparam int TX_MAX = int'(TX_OFF_COUNT) + 4;
    localparam int ID_MAX = int'(ID_READY_COUNT) + 4;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_edge_report: assert property ($changed(monitorPresent) |-> senseEvent)
        else $error("edge unreported");
    a_attach_pulse: assert property (attachEvent |-> senseEvent && monitorPresent)
        else $error("attach pulse wrong");
    a_remove_pulse: assert property (removeEvent |-> senseEvent && !monitorPresent)
        else $error("removal pulse wrong");
    a_sync_high: assert property (hotAttachSense [*5] |-> monitorPresent)
        else $error("present not set");
    a_sync_low: assert property (!hotAttachSense [*5] |-> !monitorPresent)
        else $error("present not cleared");
    a_tx_deadline: assert property (removeEvent |-> ##[0:TX_MAX] !txEnable)
        else $error("transmitter left on");
    a_low_target: assert property (lowFormatOnly [*2] |-> scaleTargetH == LOW_FMT_H && scaleTargetV == LOW_FMT_V)
        else $error("low format target wrong");
    a_id_bound: assert property (attachEvent |-> ##[1:ID_MAX] (idReadAllowed || !monitorPresent))
        else $error("identification read not allowed");
    cover property (attachEvent);
    cover property (removeEvent);
    cover property ($fell(txEnable));
    cover property (removeEvent ##[1:20] attachEvent);
endmodule : dhp_hotplug_sva
bind dhp_hotplug dhp_hotplug_sva #(.TX_OFF_COUNT(TX_OFF_COUNT), .ID_READY_COUNT(ID_READY_COUNT)) chk_u (.*);

// ===== tb/tb_display_hotplug_edid_presence.sv
// self-checking bench for the hot attach watcher
`timescale 1ns/1ns
module tb_display_hotplug_edid_presence;
    logic core_clk = 1'b0, rst = 1'b1, plugIn = 1'b0, linkEnableReq = 1'b0, hostScaleReq = 1'b0;
    logic hotAttachSense, idDataValid, attachEvent, removeEvent, senseEvent, monitorPresent;
    logic idReadAllowed, txEnable, lowFormatOnly;
    logic [11:0] nativeH, nativeV, scaleTargetH, scaleTargetV;
    int n_errors = 0, comparisons = 0, cycles = 0, n;
    always #2 core_clk = ~core_clk;
    dhp_mon_model mon_u (.*);
    dhp_hotplug #(.TX_OFF_COUNT(32'h10), .ID_READY_COUNT(32'h8)) dut_u (.*);
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wait_for(ref logic s, input logic v, output int k);
        k = 0;
        while (s !== v && k < 100) begin
            @(negedge core_clk);
            k++;
        end
    endtask : wait_for
    task automatic t_reset();
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        chk("txEnable", 12'h0, txEnable);
        chk("lowFormatOnly", 12'h1, lowFormatOnly);
        chk("scaleTargetH", 12'h280, scaleTargetH);
        chk("scaleTargetV", 12'h1E0, scaleTargetV);
        @(posedge core_clk);
        rst <= 1'b0;
        $display("reset test done");
    endtask : t_reset
    task automatic t_attach();
        @(posedge core_clk);
        plugIn <= 1'b1;
        wait_for(attachEvent, 1'b1, n);
        chk("attachEvent", 12'h1, attachEvent);
        chk("senseEvent", 12'h1, senseEvent);
        chk("monitorPresent", 12'h1, monitorPresent);
        chk("txEnable", 12'h0, txEnable);
        chk("idReadAllowed", 12'h0, idReadAllowed);
        wait_for(idReadAllowed, 1'b1, n);
        chk("idReadAllowed", 12'h1, idReadAllowed);
        @(posedge core_clk);
        linkEnableReq <= 1'b1;
        hostScaleReq <= 1'b1;
        repeat (3) @(negedge core_clk);
        chk("txEnable", 12'h1, txEnable);
        chk("lowFormatOnly", 12'h0, lowFormatOnly);
        chk("scaleTargetH", 12'h780, scaleTargetH);
        chk("scaleTargetV", 12'h438, scaleTargetV);
        $display("attach test done");
    endtask : t_attach
    task automatic t_remove();
        @(posedge core_clk);
        plugIn <= 1'b0;
        wait_for(removeEvent, 1'b1, n);
        chk("removeEvent", 12'h1, removeEvent);
        chk("senseEvent", 12'h1, senseEvent);
        wait_for(txEnable, 1'b0, n);
        chk("txOffInTime", 12'h1, 12'(n <= 20));
        repeat (3) @(negedge core_clk);
        chk("lowFormatOnly", 12'h1, lowFormatOnly);
        chk("monitorPresent", 12'h0, monitorPresent);
        chk("idReadAllowed", 12'h0, idReadAllowed);
        $display("removal test done");
    endtask : t_remove
    task automatic t_replug();
        @(posedge core_clk);
        plugIn <= 1'b0;
        hostScaleReq <= 1'b0;
        wait_for(removeEvent, 1'b1, n);
        chk("removeEvent", 12'h1, removeEvent);
        @(posedge core_clk);
        plugIn <= 1'b1;
        wait_for(attachEvent, 1'b1, n);
        chk("attachEvent", 12'h1, attachEvent);
        @(negedge core_clk);
        chk("txEnable", 12'h0, txEnable);
        wait_for(idReadAllowed, 1'b1, n);
        repeat (3) @(negedge core_clk);
        chk("txEnable", 12'h1, txEnable);
        chk("scaleTargetH", 12'h780, scaleTargetH);
        chk("scaleTargetV", 12'h438, scaleTargetV);
        $display("replug test done");
    endtask : t_replug
    initial begin
        t_reset();
        t_attach();
        t_replug();
        t_remove();
        stop_test();
    end
endmodule : tb_display_hotplug_edid_presence
